/* File: rtl/csi_core_ctrl.sv */
/*
  Register file, pointers, stack pointer and vectored interrupt control.
  Assumes the execute stage drives op_i, instr_end_i and pc_i on the core
  clock, and that data memory returns read data one cycle after dm_re_o.
*/
// How it works
// [RULE1] Four read/write port schemes, 8 and 16 bit
// [RULE2] Registers mapped at the lowest 32 data addresses
// [RULE3] Registers 26..31 form three 16-bit pointers
// [RULE4] Pointers: displacement, post-increment, pre-decrement
// [RULE5] Push lowers stack pointer, pop raises it
// [RULE6] Call/entry push two bytes, returns pop two
// [RULE7] Stack pointer is two I/O bytes, reset high
// [RULE8] Software sets stack pointer before calls
// [RULE9] Undivided clock, single-cycle register write-back
// [RULE10] Fetch overlaps execution, stalled only by sequences
// [RULE11] Take request only with both enables set
// [RULE12] Own vectors, lower address wins, reset first
// [RULE13] Select bit and fuse move vectors to boot
// [RULE14] Boot lock bits suppress interrupts by region
// [RULE15] Entry clears global enable, return sets it
// [RULE16] Vectoring or writing one clears the flag
// [RULE17] Disabled flags stay latched, served by priority
// [RULE18] Level requests never latch
// [RULE19] One instruction runs after return before service
// [RULE20] Status register not saved nor restored
// [RULE21] Disable instruction masks at once
// [RULE22] One instruction runs after enable instruction
// [RULE23] Global enable is status bit 7
// [RULE24] Entry takes four cycles, plus four from sleep
// [RULE25] Return takes four cycles, sets global enable
// [RULE26] Lowest pending vector selected
`timescale 1ns/10ps
module csi_core_ctrl (
  input  wire logic                  core_clk_i,        // Core clock, 250 MHz
  input  wire logic                  rst_n_i,           // Sync reset, active low
  input  wire logic                  ce_i,              // Clock enable
  input  wire logic [4:0]            rd_a_idx_i,        // Operand A index
  input  wire logic [4:0]            rd_b_idx_i,        // Operand B index
  input  wire logic [3:0]            rd_w_pair_i,       // 16-bit operand pair
  output logic      [7:0]            rd_a_o,            // Operand A
  output logic      [7:0]            rd_b_o,            // Operand B
  output logic      [15:0]           rd_w_o,            // 16-bit operand
  input  wire csi_pkg::csi_wr_req_t  wr_i,              // Result write-back
  input  wire logic [15:0]           ds_addr_i,         // Data-space address
  input  wire logic                  ds_we_i,           // Data-space write
  input  wire logic [7:0]            ds_wdata_i,        // Data-space write data
  output logic                       ds_hit_o,          // Address hits registers
  output logic      [7:0]            ds_rdata_o,        // Data-space read data
  input  wire csi_pkg::csi_ptr_req_t ptr_i,             // Pointer access
  output logic      [15:0]           ptr_addr_o,        // Effective address
  input  wire logic [5:0]            io_addr_i,         // I/O address
  input  wire logic                  io_we_i,           // I/O write strobe
  input  wire logic [7:0]            io_wdata_i,        // I/O write data
  output logic      [7:0]            io_rdata_o,        // I/O read data
  input  wire logic                  status_we_i,       // ALU flag update
  input  wire logic [6:0]            status_flags_i,    // ALU flags, bits 6..0
  output logic      [7:0]            status_o,          // Status register
  input  wire csi_pkg::csi_op_t      op_i,              // Stack/enable op
  input  wire logic [7:0]            push_data_i,       // Byte to push
  input  wire logic [15:0]           pc_i,              // Return address
  input  wire logic                  instr_end_i,       // Last cycle of instr
  input  wire logic                  sleep_i,           // Core asleep
  input  wire logic [csi_pkg::NUM_IRQ-1:0] irq_event_i, // Flag-type events
  input  wire logic [csi_pkg::NUM_IRQ-1:0] irq_level_i, // Level-type conditions
  input  wire logic [csi_pkg::NUM_IRQ-1:0] irq_en_i,    // Individual enables
  input  wire logic [csi_pkg::NUM_IRQ-1:0] irq_clr_i,   // Write-one clears
  output logic [csi_pkg::NUM_IRQ-1:0] irq_flag_o,       // Latched flags
  input  wire logic                  rst_vec_fuse_i,    // Reset vector fuse
  input  wire logic                  lock_app_i,        // App lock programmed
  input  wire logic                  lock_boot_i,       // Boot lock programmed
  output logic      [15:0]           reset_vec_o,       // Reset vector
  output logic                       busy_o,            // Sequence running
  output logic                       fetch_en_o,        // Fetch may proceed
  output logic                       dm_we_o,           // Data memory write
  output logic                       dm_re_o,           // Data memory read
  output logic      [15:0]           dm_addr_o,         // Data memory address
  output logic      [7:0]            dm_wdata_o,        // Data memory data
  input  wire logic [7:0]            dm_rdata_i,        // Data memory read data
  output logic                       jump_o,            // Load PC, one pulse
  output logic      [15:0]           jump_addr_o        // New PC value
);
  csi_pkg::csi_state_t s, n;
  logic [csi_pkg::NUM_IRQ-1:0] req, higher, sel_oh;
  logic [2:0]  sel_idx;
  logic        gie, suppress, take;
  logic [15:0] ptr_val, vec_base;
  logic [3:0]  ptr_pair;

  // ---------------------------------------------------------------
  // Request gating and priority
  // ---------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < csi_pkg::NUM_IRQ; g++) begin : g_irq
      assign req[g]    = (csi_pkg::LEVEL_TYPE[g] ? irq_level_i[g] : s.flag[g]) & irq_en_i[g]; // RULE11 RULE18
      assign higher[g] = (g == 0) ? 1'b0 : |req[g > 0 ? g-1 : 0:0];
      assign sel_oh[g] = req[g] & ~higher[g]; // RULE26 RULE12
    end
  endgenerate

  always_comb begin
    sel_idx = 3'h0;
    for (int k = 0; k < csi_pkg::NUM_IRQ; k++) begin
      if (sel_oh[k]) begin
        sel_idx = 3'(k);
      end
    end
  end

  assign gie = s.status[csi_pkg::GIE_BIT]; // RULE23
  assign vec_base = s.ctrl[csi_pkg::VECTOR_TABLE_SELECT_BIT] ? csi_pkg::BOOT_START : 16'h0000; // RULE13
  // Vectors in the other section are blocked when that section is locked
  assign suppress = (lock_app_i & ~s.ctrl[csi_pkg::VECTOR_TABLE_SELECT_BIT] & (pc_i >= csi_pkg::BOOT_START))
                  | (lock_boot_i & s.ctrl[csi_pkg::VECTOR_TABLE_SELECT_BIT] & (pc_i < csi_pkg::BOOT_START)); // RULE14
  // CLI in the same cycle masks at once; hold delays one instruction
  assign take = (s.seq == csi_pkg::SQ_IDLE) & (instr_end_i | sleep_i) & (op_i == csi_pkg::OP_NONE)
              & gie & ~s.hold & ~suppress & (|req); // RULE11 RULE19 RULE21 RULE22

  // ---------------------------------------------------------------
  // Register file read ports and pointers
  // ---------------------------------------------------------------
  assign rd_a_o = s.gpr[rd_a_idx_i]; // RULE1
  assign rd_b_o = s.gpr[rd_b_idx_i];
  assign rd_w_o = {s.gpr[{rd_w_pair_i, 1'b1}], s.gpr[{rd_w_pair_i, 1'b0}]};
  assign ds_hit_o   = ds_addr_i < csi_pkg::DS_REG_TOP; // RULE2
  assign ds_rdata_o = ds_hit_o ? s.gpr[ds_addr_i[4:0]] : 8'h00;

  always_comb begin
    ptr_pair = csi_pkg::PAIR_X;
    case (ptr_i.sel)
      2'h1:    ptr_pair = csi_pkg::PAIR_Y;
      2'h2:    ptr_pair = csi_pkg::PAIR_Z;
      default: ptr_pair = csi_pkg::PAIR_X;
    endcase
    ptr_val = {s.gpr[{ptr_pair, 1'b1}], s.gpr[{ptr_pair, 1'b0}]}; // RULE3
    case (ptr_i.mode)
      csi_pkg::PM_DISP:   ptr_addr_o = ptr_val + {10'h000, ptr_i.disp}; // RULE4
      csi_pkg::PM_PREDEC: ptr_addr_o = ptr_val - 16'h0001;
      default:            ptr_addr_o = ptr_val;
    endcase
  end

  always_comb begin
    case (io_addr_i)
      csi_pkg::IO_SPL:    io_rdata_o = s.sp[7:0]; // RULE7
      csi_pkg::IO_SPH:    io_rdata_o = s.sp[15:8];
      csi_pkg::IO_STATUS: io_rdata_o = s.status;
      csi_pkg::IO_CTRL:   io_rdata_o = s.ctrl;
      default:            io_rdata_o = 8'h00;
    endcase
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    logic [15:0] nptr;
    n = s;
    nptr = 16'h0000;
    n.dm_we = 1'b0;
    n.dm_re = 1'b0;
    n.jump  = 1'b0;
    // Result write-back lands at this edge, one cycle per ALU op
    if (wr_i.we8) begin
      n.gpr[wr_i.idx8] = wr_i.data8; // RULE9 RULE1
    end
    if (wr_i.we16) begin
      n.gpr[{wr_i.pair16, 1'b0}] = wr_i.data16[7:0]; // RULE1
      n.gpr[{wr_i.pair16, 1'b1}] = wr_i.data16[15:8];
    end
    if (ds_we_i && ds_hit_o) begin
      n.gpr[ds_addr_i[4:0]] = ds_wdata_i; // RULE2
    end
    if (ptr_i.go && (ptr_i.mode == csi_pkg::PM_POSTINC || ptr_i.mode == csi_pkg::PM_PREDEC)) begin
      nptr = (ptr_i.mode == csi_pkg::PM_POSTINC) ? ptr_val + 16'h0001 : ptr_val - 16'h0001; // RULE4
      n.gpr[{ptr_pair, 1'b0}] = nptr[7:0];
      n.gpr[{ptr_pair, 1'b1}] = nptr[15:8];
    end
    // Status is only touched by ALU, software and the enable bit
    if (status_we_i) begin
      n.status[6:0] = status_flags_i; // RULE20
    end
    if (io_we_i) begin
      case (io_addr_i)
        csi_pkg::IO_SPL:    n.sp = {s.sp[15:8], io_wdata_i} & csi_pkg::SP_IMPL_MASK; // RULE7
        csi_pkg::IO_SPH:    n.sp = {io_wdata_i, s.sp[7:0]} & csi_pkg::SP_IMPL_MASK;
        csi_pkg::IO_STATUS: n.status = io_wdata_i;
        csi_pkg::IO_CTRL:   n.ctrl = io_wdata_i;
        default:            n.ctrl = s.ctrl;
      endcase
    end
    // Set wins over clear; vectoring clears only the served flag
    n.flag = (s.flag & ~irq_clr_i & ~(take ? sel_oh : '0)) | (irq_event_i & ~csi_pkg::LEVEL_TYPE); // RULE16 RULE17
    if (instr_end_i && s.seq == csi_pkg::SQ_IDLE) begin
      n.hold = 1'b0; // RULE19 RULE22
    end
    case (s.seq)
      csi_pkg::SQ_IDLE: begin
        if (take) begin
          n.status[csi_pkg::GIE_BIT] = 1'b0; // RULE15
          n.vec_idx  = sel_idx;
          n.ret_pc   = pc_i;
          n.irq_seq  = 1'b1;
          n.interrupt_exit_instruction_seq = 1'b0;
          n.cnt      = csi_pkg::ENTRY_CYCLES - 4'h2 + (sleep_i ? csi_pkg::WAKE_CYCLES : 4'h0); // RULE24
          n.seq      = csi_pkg::SQ_PUSH_LO;
        end else begin
          case (op_i)
            csi_pkg::OP_PUSH: begin
              n.dm_we    = 1'b1;
              n.dm_addr  = s.sp;
              n.dm_wdata = push_data_i;
              n.sp       = s.sp - 16'h0001; // RULE5
            end
            csi_pkg::OP_POP: begin
              n.dm_re   = 1'b1;
              n.dm_addr = s.sp + 16'h0001;
              n.sp      = s.sp + 16'h0001; // RULE5
            end
            csi_pkg::OP_CALL: begin
              n.ret_pc  = pc_i;
              n.irq_seq = 1'b0;
              n.cnt     = csi_pkg::ENTRY_CYCLES - 4'h2;
              n.seq     = csi_pkg::SQ_PUSH_LO; // RULE6
            end
            csi_pkg::OP_RET, csi_pkg::OP_INTERRUPT_EXIT_INSTRUCTION: begin
              n.irq_seq  = 1'b0;
              n.interrupt_exit_instruction_seq = (op_i == csi_pkg::OP_INTERRUPT_EXIT_INSTRUCTION);
              n.ret_seq  = 1'b1;
              n.cnt      = csi_pkg::RETURN_CYCLES - 4'h3;
              n.seq      = csi_pkg::SQ_POP_HI; // RULE6 RULE25
            end
            csi_pkg::OP_SEI: begin
              n.status[csi_pkg::GIE_BIT] = 1'b1;
              n.hold = 1'b1; // RULE22
            end
            csi_pkg::OP_CLI: n.status[csi_pkg::GIE_BIT] = 1'b0; // RULE21
            default: n.seq = csi_pkg::SQ_IDLE;
          endcase
        end
      end
      // Low byte goes to the higher address, so a pop yields high first
      csi_pkg::SQ_PUSH_LO: begin
        n.dm_we    = 1'b1;
        n.dm_addr  = s.sp;
        n.dm_wdata = s.ret_pc[7:0];
        n.sp       = s.sp - 16'h0001; // RULE6
        n.seq      = csi_pkg::SQ_PUSH_HI;
      end
      csi_pkg::SQ_PUSH_HI: begin
        n.dm_we    = 1'b1;
        n.dm_addr  = s.sp;
        n.dm_wdata = s.ret_pc[15:8];
        n.sp       = s.sp - 16'h0001; // RULE6
        n.seq      = csi_pkg::SQ_WAIT;
      end
      csi_pkg::SQ_POP_HI: begin
        n.dm_re   = 1'b1;
        n.dm_addr = s.sp + 16'h0001;
        n.sp      = s.sp + 16'h0001; // RULE6
        n.seq     = csi_pkg::SQ_POP_LO;
      end
      csi_pkg::SQ_POP_LO: begin
        n.dm_re   = 1'b1;
        n.dm_addr = s.sp + 16'h0001;
        n.sp      = s.sp + 16'h0001;
        n.seq     = csi_pkg::SQ_POP_CAP;
      end
      csi_pkg::SQ_POP_CAP: begin
        n.ret_pc[15:8] = dm_rdata_i;
        n.seq          = csi_pkg::SQ_WAIT;
      end
      csi_pkg::SQ_WAIT: begin
        if (s.cnt <= 4'h1) begin
          n.seq  = csi_pkg::SQ_IDLE;
          // Calls end silently; only entries and returns load the PC
          n.jump      = s.irq_seq | s.ret_seq;
          n.jump_addr = s.ret_seq ? {s.ret_pc[15:8], dm_rdata_i}
                                  : vec_base + csi_pkg::VEC_STRIDE * ({13'h0000, s.vec_idx} + 16'h0001); // RULE12
          n.ret_seq   = 1'b0;
          if (s.interrupt_exit_instruction_seq) begin
            n.status[csi_pkg::GIE_BIT] = 1'b1; // RULE25 RULE15
            n.hold     = 1'b1; // RULE19
            n.interrupt_exit_instruction_seq = 1'b0;
          end
        end else begin
          n.cnt = s.cnt - 4'h1;
        end
      end
      default: n.seq = csi_pkg::SQ_IDLE;
    endcase
  end

  // Call pushes leave no jump; the execute stage already knows the target
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      s    <= '0;
      s.sp <= csi_pkg::TOP_OF_DATA_MEMORY; // RULE7 RULE8
    end else if (ce_i) begin
      s <= n;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign busy_o      = s.seq != csi_pkg::SQ_IDLE;
  assign fetch_en_o  = ~busy_o & ~take; // RULE10
  assign status_o    = s.status;
  assign irq_flag_o  = s.flag;
  assign dm_we_o     = s.dm_we;
  assign dm_re_o     = s.dm_re;
  assign dm_addr_o   = s.dm_addr;
  assign dm_wdata_o  = s.dm_wdata;
  assign jump_o      = s.jump;
  assign jump_addr_o = s.jump_addr;
  assign reset_vec_o = rst_vec_fuse_i ? csi_pkg::BOOT_START : 16'h0000; // RULE13 RULE12

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  property p_push_dec;
    ce_i && !take && s.seq == csi_pkg::SQ_IDLE && op_i == csi_pkg::OP_PUSH && !io_we_i
      |=> s.sp == $past(s.sp) - 16'h0001 && dm_we_o;
  endproperty
  a_push_dec: assert property (p_push_dec) else $error("push did not lower sp by one"); // RULE5

  property p_call_dec2;
    (ce_i && !take && s.seq == csi_pkg::SQ_IDLE && op_i == csi_pkg::OP_CALL && !io_we_i) ##1 (ce_i && !io_we_i)[*4]
      |=> s.sp == $past(s.sp, 5) - 16'h0002;
  endproperty
  a_call_dec2: assert property (p_call_dec2) else $error("call did not lower sp by two"); // RULE6

  property p_interrupt_exit_instruction_len;
    (ce_i && !take && s.seq == csi_pkg::SQ_IDLE && op_i == csi_pkg::OP_INTERRUPT_EXIT_INSTRUCTION && !io_we_i && !status_we_i)
      ##1 (ce_i && !io_we_i)[*4]
      |=> jump_o && gie && s.sp == $past(s.sp, 5) + 16'h0002;
  endproperty
  a_interrupt_exit_instruction_len: assert property (p_interrupt_exit_instruction_len) else $error("return not four cycles or gie unset"); // RULE25

  property p_take_gated;
    take |-> gie && (|(irq_en_i & sel_oh)) && !suppress;
  endproperty
  a_take_gated: assert property (p_take_gated) else $error("request taken while disabled"); // RULE11

  property p_entry_len;
    (take && ce_i && !sleep_i && !io_we_i) ##1 (ce_i && !io_we_i)[*4] |=> jump_o && !gie;
  endproperty
  a_entry_len: assert property (p_entry_len) else $error("entry not four cycles"); // RULE24

  property p_cli_masks;
    ce_i && s.seq == csi_pkg::SQ_IDLE && op_i == csi_pkg::OP_CLI |-> !take ##1 !gie;
  endproperty
  a_cli_masks: assert property (p_cli_masks) else $error("cli did not mask"); // RULE21

  property p_hold_blocks;
    s.hold |-> !take;
  endproperty
  a_hold_blocks: assert property (p_hold_blocks) else $error("served before one instruction"); // RULE19

  property p_flag_latch;
    ce_i && irq_event_i[0] |=> s.flag[0];
  endproperty
  a_flag_latch: assert property (p_flag_latch) else $error("event lost"); // RULE17

  property p_priority;
    take |-> sel_oh == (req & (~req + 8'h01));
  endproperty
  a_priority: assert property (p_priority) else $error("not lowest vector"); // RULE26

  c_take: cover property (take ##5 jump_o);
  c_interrupt_exit_instruction: cover property (s.seq == csi_pkg::SQ_IDLE && op_i == csi_pkg::OP_INTERRUPT_EXIT_INSTRUCTION ##5 jump_o);
  c_sei:  cover property (op_i == csi_pkg::OP_SEI && |req ##1 s.hold);
endmodule : csi_core_ctrl

/* File: rtl/csi_pkg.sv */
/*
  Shared constants and types for the core stack and interrupt control block.
  Assumes a single 250 MHz core clock and same-clock peripheral request logic.
*/
package csi_pkg;
  // ---------------------------------------------------------------
  // Sizes and I/O offsets
  // ---------------------------------------------------------------
  localparam int unsigned NUM_REGS  = 32;
  localparam int unsigned NUM_IRQ   = 8;
  localparam logic [5:0]  IO_SPL    = 6'h3d;
  localparam logic [5:0]  IO_SPH    = 6'h3e;
  localparam logic [5:0]  IO_STATUS = 6'h3f;
  localparam logic [5:0]  IO_CTRL   = 6'h35;
  localparam int unsigned GIE_BIT   = 7;
  localparam int unsigned VECTOR_TABLE_SELECT_BIT = 1;
  localparam logic [3:0]  PAIR_X    = 4'hd;
  localparam logic [3:0]  PAIR_Y    = 4'he;
  localparam logic [3:0]  PAIR_Z    = 4'hf;
  localparam logic [15:0] DS_REG_TOP = 16'h0020;
  // ---------------------------------------------------------------
  // Memory layout and reset values
  // ---------------------------------------------------------------
  localparam logic [15:0] TOP_OF_DATA_MEMORY = 16'h04ff;
  localparam logic [15:0] SP_IMPL_MASK       = 16'h07ff;
  localparam logic [15:0] BOOT_START         = 16'h0c00;
  localparam logic [15:0] VEC_STRIDE         = 16'h0002;
  localparam logic [7:0]  LEVEL_TYPE         = 8'h80;
  // ---------------------------------------------------------------
  // Sequence lengths in clock cycles
  // ---------------------------------------------------------------
  localparam logic [3:0] ENTRY_CYCLES  = 4'h4;
  localparam logic [3:0] RETURN_CYCLES = 4'h4;
  localparam logic [3:0] WAKE_CYCLES   = 4'h4;
  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {OP_NONE, OP_PUSH, OP_POP, OP_CALL, OP_RET, OP_INTERRUPT_EXIT_INSTRUCTION, OP_SEI, OP_CLI} csi_op_t;
  typedef enum logic [1:0] {PM_PLAIN, PM_DISP, PM_POSTINC, PM_PREDEC} csi_pmode_t;
  typedef enum logic [2:0] {SQ_IDLE, SQ_PUSH_LO, SQ_PUSH_HI, SQ_POP_HI, SQ_POP_LO, SQ_POP_CAP, SQ_WAIT} csi_seq_t;
  typedef struct packed {
    logic       go;
    logic [1:0] sel;
    csi_pmode_t mode;
    logic [5:0] disp;
  } csi_ptr_req_t;
  typedef struct packed {
    logic        we8;
    logic [4:0]  idx8;
    logic [7:0]  data8;
    logic        we16;
    logic [3:0]  pair16;
    logic [15:0] data16;
  } csi_wr_req_t;
  typedef struct packed {
    logic [NUM_REGS-1:0][7:0] gpr;
    logic [15:0]        sp;
    logic [7:0]         status;
    logic [7:0]         ctrl;
    logic [NUM_IRQ-1:0] flag;
    logic               hold;
    csi_seq_t           seq;
    logic [3:0]         cnt;
    logic               irq_seq;
    logic               interrupt_exit_instruction_seq;
    logic               ret_seq;
    logic [15:0]        ret_pc;
    logic [2:0]         vec_idx;
    logic               dm_we;
    logic               dm_re;
    logic [15:0]        dm_addr;
    logic [7:0]         dm_wdata;
    logic               jump;
    logic [15:0]        jump_addr;
  } csi_state_t;
endpackage : csi_pkg

/* File: tb/csi_dmem.sv */
/*
  Data memory model for the stack side of the core control block.
  Assumes one clock and read data due the cycle after a read strobe.
*/
`timescale 1ns/10ps
module csi_dmem (
  input  wire logic        core_clk_i,         // Core clock
  input  wire logic        dm_we_i,            // Write strobe
  input  wire logic        dm_re_i,            // Read strobe
  input  wire logic [15:0] dm_addr_i,          // Byte address
  input  wire logic [7:0]  dm_wdata_i,         // Write data
  output logic      [7:0]  dm_rdata_o = 8'h00  // Read data
);
  logic [7:0] mem [0:2047];
  // Toggles outside reads so stale data never passes for valid
  always_ff @(posedge core_clk_i) begin
    if (dm_we_i) begin
      mem[dm_addr_i[10:0]] <= dm_wdata_i;
    end
    dm_rdata_o <= dm_re_i ? mem[dm_addr_i[10:0]] : ~dm_rdata_o;
  end
endmodule : csi_dmem

/* File: tb/tb_top.sv */
/*
  Self-checking bench for the core stack and interrupt control block.
  Assumes the design files and the data memory model are compiled first.
*/
`timescale 1ns/10ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin bad_count++; \
  $display("Error t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_top;
  logic core_clk_i, rst_n_i, ce_i, ds_we_i, ds_hit_o, io_we_i, status_we_i, instr_end_i, sleep_i;
  logic rst_vec_fuse_i, lock_app_i, lock_boot_i, busy_o, fetch_en_o, dm_we_o, dm_re_o, jump_o;
  logic [4:0]  rd_a_idx_i, rd_b_idx_i;
  logic [3:0]  rd_w_pair_i;
  logic [5:0]  io_addr_i;
  logic [6:0]  status_flags_i;
  logic [7:0]  rd_a_o, rd_b_o, ds_wdata_i, ds_rdata_o, io_wdata_i, io_rdata_o, status_o, push_data_i;
  logic [7:0]  dm_wdata_o, dm_rdata_i, irq_event_i, irq_level_i, irq_en_i, irq_clr_i, irq_flag_o;
  logic [15:0] rd_w_o, ds_addr_i, ptr_addr_o, pc_i, reset_vec_o, dm_addr_o, jump_addr_o;
  csi_pkg::csi_wr_req_t  wr_i;
  csi_pkg::csi_ptr_req_t ptr_i;
  csi_pkg::csi_op_t      op_i;
  int                    bad_count, n_compared;

  csi_core_ctrl csi_core_ctrl_i (.*);
  csi_dmem csi_dmem_i (.core_clk_i, .dm_we_i(dm_we_o), .dm_re_i(dm_re_o), .dm_addr_i(dm_addr_o),
                       .dm_wdata_i(dm_wdata_o), .dm_rdata_o(dm_rdata_i));
  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic tick(input int n = 1);
    repeat (n) @(negedge core_clk_i);
  endtask : tick
  task automatic op(input csi_pkg::csi_op_t o);
    op_i = o;
    tick();
    op_i = csi_pkg::OP_NONE;
  endtask : op
  task automatic io_wr(input logic [5:0] a, input logic [7:0] d);
    io_addr_i = a;
    io_wdata_i = d;
    io_we_i = 1'b1;
    tick();
    io_we_i = 1'b0;
  endtask : io_wr
  task automatic chk_sp(input logic [15:0] e);
    io_addr_i = csi_pkg::IO_SPL;
    #0.5 `CHK(io_rdata_o, e[7:0])
    io_addr_i = csi_pkg::IO_SPH;
    #0.5 `CHK(io_rdata_o, e[15:8])
  endtask : chk_sp
  task automatic instr();
    instr_end_i = 1'b1;
    tick();
    instr_end_i = 1'b0;
  endtask : instr
  // Bounded wait; entry and return both finish well inside it
  task automatic wait_jump();
    for (int i = 0; i < 20 && jump_o !== 1'b1; i++) tick();
    `CHK(jump_o, 1'b1)
  endtask : wait_jump
  task automatic stop_test();
    if (bad_count == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : stop_test
  // ---------------------------------------------------------------
  // Clock, watchdog and test sequence
  // ---------------------------------------------------------------
  initial begin
    core_clk_i = 1'b0;
    forever #2 core_clk_i = ~core_clk_i;
  end
  // Whole sequence needs about 55 cycles
  initial begin
    #20000;
    bad_count++;
    stop_test();
  end
  initial begin
    {rst_n_i, ds_we_i, io_we_i, status_we_i, instr_end_i, sleep_i} = '0;
    {rst_vec_fuse_i, lock_app_i, lock_boot_i} = '0;
    {rd_a_idx_i, rd_b_idx_i, rd_w_pair_i, ds_addr_i, ds_wdata_i, io_addr_i, io_wdata_i} = '0;
    {status_flags_i, push_data_i, irq_event_i, irq_level_i, irq_en_i, irq_clr_i} = '0;
    {wr_i, ptr_i} = '0;
    ce_i = 1'b1;
    pc_i = 16'h0123;
    op_i = csi_pkg::OP_NONE;
    bad_count = 0;
    n_compared = 0;
    tick(5);
    rst_n_i = 1'b1;
    tick();
    chk_sp(16'h04ff);
    wr_i.we8 = 1'b1;
    wr_i.idx8 = 5'h03;
    wr_i.data8 = 8'h5a;
    tick();
    wr_i = '0;
    rd_a_idx_i = 5'h03;
    ds_addr_i = 16'h0003;
    #1 `CHK(rd_a_o, 8'h5a)
    `CHK({ds_hit_o, ds_rdata_o}, 9'h15a)
    wr_i.we16 = 1'b1;
    wr_i.pair16 = csi_pkg::PAIR_X;
    wr_i.data16 = 16'h0100;
    tick();
    wr_i = '0;
    ptr_i.go = 1'b1;
    ptr_i.mode = csi_pkg::PM_POSTINC;
    #1 `CHK(ptr_addr_o, 16'h0100)
    tick();
    ptr_i = '0;
    rd_w_pair_i = csi_pkg::PAIR_X;
    #1 `CHK(rd_w_o, 16'h0101)
    io_wr(csi_pkg::IO_SPL, 8'h00);
    io_wr(csi_pkg::IO_SPH, 8'h03);
    push_data_i = 8'ha5;
    op(csi_pkg::OP_PUSH);
    chk_sp(16'h02ff);
    op(csi_pkg::OP_POP);
    tick(2);
    chk_sp(16'h0300);
    irq_en_i = 8'h06;
    irq_event_i = 8'h06;
    tick();
    irq_event_i = 8'h00;
    instr();
    `CHK(busy_o, 1'b0)
    `CHK(irq_flag_o, 8'h06)
    op(csi_pkg::OP_SEI);
    `CHK(status_o[7], 1'b1)
    instr();
    `CHK(busy_o, 1'b0)
    instr();
    `CHK({busy_o, status_o[7], irq_flag_o}, 10'h204)
    wait_jump();
    `CHK(jump_addr_o, 16'h0004)
    chk_sp(16'h02fe);
    tick();
    op(csi_pkg::OP_INTERRUPT_EXIT_INSTRUCTION);
    wait_jump();
    `CHK(jump_addr_o, 16'h0123)
    `CHK(status_o[7], 1'b1)
    chk_sp(16'h0300);
    instr();
    `CHK(busy_o, 1'b0)
    instr();
    wait_jump();
    `CHK(jump_addr_o, 16'h0006)
    `CHK(reset_vec_o, 16'h0000)
    rst_vec_fuse_i = 1'b1;
    #0.5 `CHK(reset_vec_o, csi_pkg::BOOT_START)
    tick();
    op(csi_pkg::OP_CALL);
    `CHK({busy_o, fetch_en_o}, 2'b10)
    for (int i = 0; i < 6; i++) begin
      tick();
      `CHK(jump_o, 1'b0)
    end
    chk_sp(16'h02fc);
    tick();
    op(csi_pkg::OP_RET);
    wait_jump();
    `CHK({status_o[7], jump_addr_o}, 17'h00123)
    chk_sp(16'h02fe);
    tick();
    irq_en_i = 8'h80;
    irq_level_i = 8'h80;
    op(csi_pkg::OP_SEI);
    instr();
    instr_end_i = 1'b1;
    op(csi_pkg::OP_CLI);
    instr_end_i = 1'b0;
    tick();
    `CHK({busy_o, status_o[7]}, 2'b00)
    `CHK(irq_flag_o[7], 1'b0)
    irq_level_i = 8'h00;
    stop_test();
  end
endmodule : tb_top
